// File: design/lfkc_pkg.sv
package lfkc_pkg;
	// ****************************************
	// clock and timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 25;
	localparam int TICK_TIME_MS = 100;
	localparam int TICK_CYCLES = TICK_TIME_MS * 1000000 / CLK_PERIOD_NS;
	localparam int TICK_W = 22;
	localparam logic [7:0] MOVE_TENTHS [10] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h07,
		8'h0A, 8'h0F, 8'h14, 8'h1E, 8'h32};
	localparam logic [7:0] UNC_STEP_MIN = 8'h04;
	localparam logic [7:0] UNC_STEP_MULT = 8'h04;

	// ****************************************
	// sizes
	// ****************************************
	localparam int NUM_OUT = 14;
	localparam int NUM_MAP = 14;
	localparam int NUM_KEY = 13;
	localparam int NUM_EFFECT = 8;

	// ****************************************
	// register offsets (byte addresses)
	// ****************************************
	localparam logic [11:0] CTRL_OFF = 12'h400;
	localparam logic [11:0] AUTO_OFF_OFF = 12'h404;
	localparam logic [11:0] STAT_OFF = 12'h408;
	localparam int STAT_STATE_LSB = 16;
	localparam int STAT_STEP_LSB = 24;

	// ****************************************
	// setup variable indices (byte address = index * 4)
	// ****************************************
	localparam int CV_ADDR_SHORT = 1;
	localparam int CV_ADDR_LONG_HI = 17;
	localparam int CV_ADDR_LONG_LO = 18;
	localparam int CV_ACCEL = 3;
	localparam int CV_DECEL = 4;
	localparam int CV_KEYMAP0 = 33;
	localparam int CV_EXTMAP = 61;
	localparam int CV_COUPLER_LIMIT = 115;
	localparam int CV_UNCOUPLE = 116;
	localparam int CV_SHUNT = 124;
	localparam int CV_EFFECT0 = 125;

	// ****************************************
	// field layouts and reset values
	// ****************************************
	localparam int SK_MAN = 0;
	localparam int SK_HALF = 1;
	localparam int SK_F4 = 2;
	localparam int SK_F7L = 3;
	localparam int SK_F3L = 4;
	localparam int SK_F3S = 5;
	localparam logic [1:0] DIR_FWD_ONLY = 2'h1;
	localparam logic [1:0] DIR_REV_ONLY = 2'h2;
	localparam logic [7:0] EXT_SWISS_A = 8'h06;
	localparam logic [7:0] EXT_SWISS_B = 8'h07;
	localparam logic [7:0] EXT_FREE = 8'h62;
	localparam logic [7:0] HUNDRED = 8'h64;
	localparam logic [3:0] CTRL_RST = 4'h2;
	localparam logic [13:0] AUTO_OFF_RST = 14'h0000;
	localparam logic [7:0] KEYMAP_RST [NUM_MAP] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h02, 8'h04,
		8'h08, 8'h10, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [2:0] {
		SEQ_IDLE = 3'b000,
		SEQ_WAIT = 3'b001,
		SEQ_PUSH = 3'b010,
		SEQ_MOVE = 3'b011,
		SEQ_DONE = 3'b100
	} lfkc_seq_e;

	typedef struct packed {
		logic valid;
		logic [11:0] addr;
	} lfkc_wr_s;
endpackage : lfkc_pkg

// File: design/lfkc_top.sv
// Decided for this implementation: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - tens digit of uncoupling setup sets move-away time, 0.1 to 5 s
// - ones digit selects move-away internal speed step 4 to 36
// - move-away uses the normal acceleration and deceleration momentum
// - nonzero hundreds digit first pushes opposite way to relieve coupler tension
// - sequence enabled only when tens digit is nonzero
// - start on coupler activation at rest, or at standstill while still active
// - end on coupler off, coupler time limit or move-away time limit
// - any cab speed change aborts a running sequence at once
// - travel follows cab direction except in the push phase; coupler output ignores effect direction bits
// - manual key, F4 or F3 may act as momentum-reducing shunting key
// - F7 or F3 may act as low gear, halving the speed range
// - main-track writes accepted for all variables except address ones
// - drive fourteen function outputs switched by cab key states
// - standard key maps assign outputs; only headlight key is directional
// - extended selector: fixed modes incl. 6 and 7, free mode 98
// - free mode switches designated outputs off at standstill, except the output set as coupler output
// - effect bits 0 and 1 give direction only when bits 2 to 7 zero
// - effect direction 1 means forward only, 2 means reverse only
// - in the key maps of F0 to F2, bit 2 selects aux output one, bit 3 aux output two
// - a key map may select several outputs; outputs OR all mapped keys
// - defaults give each key map its same-numbered output, so key F1 drives output 2
module lfkc_top #(
	parameter int TICK_CYCLES = lfkc_pkg::TICK_CYCLES
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [12:0] fkeys,
	input wire logic manual_key,
	input wire logic cab_fwd,
	input wire logic [6:0] cab_speed,
	input wire logic loco_stopped,
	input wire logic pom_valid,
	input wire logic [7:0] pom_cv,
	input wire logic [7:0] pom_data,
	output logic [13:0] func_out,
	output logic [7:0] target_step,
	output logic drive_fwd,
	output logic [7:0] accel_rate,
	output logic [7:0] decel_rate,
	output logic uncouple_active
);
	// ****************************************
	// bus slave
	// ****************************************
	logic [7:0] cv_q [256];
	logic [3:0] ctrl_q;
	logic [13:0] auto_off_q;
	logic [31:0] hrdata_q;
	lfkc_pkg::lfkc_wr_s wr_q;
	lfkc_pkg::lfkc_seq_e seq_q;
	logic [13:0] func_out_q;
	logic [7:0] target_step_q;
	logic drive_fwd_q;
	logic [7:0] accel_rate_q;
	logic [7:0] decel_rate_q;
	logic acc;
	logic [31:0] rd_val;
	logic pom_ok;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;
	assign acc = hsel & hready & htrans[1];

	always_comb begin
		rd_val = 32'h0000_0000;
		if (haddr[11:10] == 2'b00) begin
			rd_val = {24'h00_0000, cv_q[haddr[9:2]]};
		end else if (haddr[11:0] == lfkc_pkg::CTRL_OFF) begin
			rd_val = {28'h000_0000, ctrl_q};
		end else if (haddr[11:0] == lfkc_pkg::AUTO_OFF_OFF) begin
			rd_val = {18'h0_0000, auto_off_q};
		end else if (haddr[11:0] == lfkc_pkg::STAT_OFF) begin
			rd_val = {target_step_q, 5'h00, seq_q, 2'h0, func_out_q};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= '0;
			hrdata_q <= 32'h0000_0000;
		end else begin
			wr_q.valid <= acc & hwrite;
			wr_q.addr <= haddr[11:0];
			hrdata_q <= (acc & !hwrite) ? rd_val : 32'h0000_0000;
		end
	end

	// main-track writes may not touch the address variables
	assign pom_ok = pom_valid && pom_cv != 8'(lfkc_pkg::CV_ADDR_SHORT)
		&& pom_cv != 8'(lfkc_pkg::CV_ADDR_LONG_HI) && pom_cv != 8'(lfkc_pkg::CV_ADDR_LONG_LO);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 256; i++) begin
				cv_q[i] <= 8'h00;
			end
			for (int m = 0; m < lfkc_pkg::NUM_MAP; m++) begin
				cv_q[lfkc_pkg::CV_KEYMAP0 + m] <= lfkc_pkg::KEYMAP_RST[m];
			end
			ctrl_q <= lfkc_pkg::CTRL_RST;
			auto_off_q <= lfkc_pkg::AUTO_OFF_RST;
		end else begin
			if (wr_q.valid && wr_q.addr[11:10] == 2'b00) begin
				cv_q[wr_q.addr[9:2]] <= hwdata[7:0];
			end
			if (wr_q.valid && wr_q.addr == lfkc_pkg::CTRL_OFF) begin
				ctrl_q <= hwdata[3:0];
			end
			if (wr_q.valid && wr_q.addr == lfkc_pkg::AUTO_OFF_OFF) begin
				auto_off_q <= hwdata[13:0];
			end
			if (pom_ok) begin
				cv_q[pom_cv] <= pom_data;
			end
		end
	end

	pom_protect_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(pom_valid && pom_cv == 8'h01 && !wr_q.valid) |=> $stable(cv_q[1]))
		else $error("address variable changed by main-track write");

	// ****************************************
	// tenth-second tick
	// ****************************************
	logic [lfkc_pkg::TICK_W-1:0] tick_cnt_q;
	logic tick;

	assign tick = tick_cnt_q == lfkc_pkg::TICK_W'(TICK_CYCLES - 1);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
		end
	end

	// ****************************************
	// function mapping
	// ****************************************
	logic [13:0] contrib [lfkc_pkg::NUM_MAP];
	logic [13:0] raw;
	logic [13:0] swiss;
	logic [13:0] out_d;
	logic [7:0] ext_mode;
	logic coupler_raw;
	logic coupler_on;
	logic coupler_exp_q;

	assign ext_mode = cv_q[lfkc_pkg::CV_EXTMAP];

	for (genvar m = 0; m < lfkc_pkg::NUM_MAP; m++) begin : g_map
		localparam int SH = (m < 4) ? 0 : ((m < 8) ? 3 : 6);
		logic act;
		if (m == 0) begin : g_f0f
			assign act = fkeys[0] & cab_fwd;
		end else if (m == 1) begin : g_f0r
			assign act = fkeys[0] & !cab_fwd;
		end else begin : g_fn
			assign act = fkeys[m - 1];
		end
		assign contrib[m] = act ? ({6'h00, cv_q[lfkc_pkg::CV_KEYMAP0 + m]} << SH) : 14'h0000;
	end

	always_comb begin
		raw = 14'h0000;
		for (int m = 0; m < lfkc_pkg::NUM_MAP; m++) begin
			raw = raw | contrib[m];
		end
	end

	// fixed lighting modes: aux one and two follow the headlight key per direction
	assign swiss = (ext_mode == lfkc_pkg::EXT_SWISS_A || ext_mode == lfkc_pkg::EXT_SWISS_B)
		? {10'h000, fkeys[0] & !cab_fwd, fkeys[0] & cab_fwd, 2'b00} : 14'h0000;

	assign coupler_raw = (ctrl_q < 4'(lfkc_pkg::NUM_OUT)) ? raw[ctrl_q] : 1'b0;
	assign coupler_on = coupler_raw & !coupler_exp_q;

	for (genvar i = 0; i < lfkc_pkg::NUM_OUT; i++) begin : g_out
		logic dir_ok;
		logic auto_off;
		if (i < lfkc_pkg::NUM_EFFECT) begin : g_eff
			logic [7:0] eff;
			assign eff = cv_q[lfkc_pkg::CV_EFFECT0 + i];
			assign dir_ok = (eff[7:2] != 6'h00)
				|| !(eff[1:0] == lfkc_pkg::DIR_FWD_ONLY || eff[1:0] == lfkc_pkg::DIR_REV_ONLY)
				|| (eff[1:0] == lfkc_pkg::DIR_FWD_ONLY && cab_fwd)
				|| (eff[1:0] == lfkc_pkg::DIR_REV_ONLY && !cab_fwd);
		end else begin : g_noeff
			assign dir_ok = 1'b1;
		end
		assign auto_off = ext_mode == lfkc_pkg::EXT_FREE && auto_off_q[i] && loco_stopped;
		assign out_d[i] = (ctrl_q == 4'(i)) ? coupler_on
			: ((raw[i] | swiss[i]) & dir_ok & !auto_off);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			func_out_q <= 14'h0000;
		end else begin
			func_out_q <= out_d;
		end
	end

	assign func_out = func_out_q;

	fwd_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(ctrl_q != 4'h2 && cv_q[lfkc_pkg::CV_EFFECT0 + 2] == 8'h01 && !cab_fwd) |=> !func_out_q[2])
		else $error("forward-only output lit in reverse");

	auto_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(ext_mode == lfkc_pkg::EXT_FREE && auto_off_q[0] && loco_stopped && ctrl_q != 4'h0)
		|=> !func_out_q[0])
		else $error("designated output not switched off at standstill");

	// ****************************************
	// coupler time limit
	// ****************************************
	logic [7:0] cpl_cnt_q;
	logic [7:0] cpl_limit;

	assign cpl_limit = cv_q[lfkc_pkg::CV_COUPLER_LIMIT];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cpl_cnt_q <= 8'h00;
			coupler_exp_q <= 1'b0;
		end else if (!coupler_raw) begin
			cpl_cnt_q <= 8'h00;
			coupler_exp_q <= 1'b0;
		end else begin
			if (tick && cpl_cnt_q != 8'hFF) begin
				cpl_cnt_q <= cpl_cnt_q + 8'h01;
			end
			if (cpl_limit != 8'h00 && cpl_cnt_q >= cpl_limit) begin
				coupler_exp_q <= 1'b1;
			end
		end
	end

	// ****************************************
	// uncoupling sequence
	// ****************************************
	logic [7:0] setup;
	logic [3:0] tens;
	logic [3:0] ones;
	logic [7:0] move_tenths;
	logic [7:0] push_tenths;
	logic [7:0] move_step;
	logic [7:0] seq_tmr_q;
	logic [6:0] cab_prev_q;
	logic cpl_prev_q;
	logic cpl_rise;
	logic running;
	logic speed_chg;
	lfkc_pkg::lfkc_seq_e start_st;

	assign setup = cv_q[lfkc_pkg::CV_UNCOUPLE];
	assign tens = 4'((setup % lfkc_pkg::HUNDRED) / 8'h0A);
	assign ones = 4'(setup % 8'h0A);
	assign move_tenths = lfkc_pkg::MOVE_TENTHS[tens];
	assign push_tenths = (move_tenths + 8'h03) >> 2;
	assign move_step = (ones == 4'h0) ? lfkc_pkg::UNC_STEP_MIN : 8'(ones * lfkc_pkg::UNC_STEP_MULT);
	assign start_st = (setup >= lfkc_pkg::HUNDRED) ? lfkc_pkg::SEQ_PUSH : lfkc_pkg::SEQ_MOVE;
	assign cpl_rise = coupler_on & !cpl_prev_q;
	assign running = seq_q == lfkc_pkg::SEQ_PUSH || seq_q == lfkc_pkg::SEQ_MOVE;
	assign speed_chg = cab_speed != cab_prev_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cab_prev_q <= 7'h00;
			cpl_prev_q <= 1'b0;
		end else begin
			cab_prev_q <= cab_speed;
			cpl_prev_q <= coupler_on;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seq_q <= lfkc_pkg::SEQ_IDLE;
			seq_tmr_q <= 8'h00;
		end else begin
			case (seq_q)
				lfkc_pkg::SEQ_IDLE: begin
					seq_tmr_q <= 8'h00;
					if (cpl_rise && tens != 4'h0) begin
						seq_q <= loco_stopped ? start_st : lfkc_pkg::SEQ_WAIT;
					end
				end
				lfkc_pkg::SEQ_WAIT: begin
					if (!coupler_on) begin
						seq_q <= lfkc_pkg::SEQ_IDLE;
					end else if (loco_stopped) begin
						seq_q <= start_st;
					end
				end
				lfkc_pkg::SEQ_PUSH, lfkc_pkg::SEQ_MOVE: begin
					if (!coupler_on) begin
						seq_q <= lfkc_pkg::SEQ_IDLE;
					end else if (speed_chg) begin
						seq_q <= lfkc_pkg::SEQ_DONE;
					end else if (seq_q == lfkc_pkg::SEQ_PUSH && seq_tmr_q >= push_tenths) begin
						seq_q <= lfkc_pkg::SEQ_MOVE;
						seq_tmr_q <= 8'h00;
					end else if (seq_q == lfkc_pkg::SEQ_MOVE && seq_tmr_q >= move_tenths) begin
						seq_q <= lfkc_pkg::SEQ_DONE;
					end else if (tick) begin
						seq_tmr_q <= seq_tmr_q + 8'h01;
					end
				end
				lfkc_pkg::SEQ_DONE: begin
					if (!coupler_on) begin
						seq_q <= lfkc_pkg::SEQ_IDLE;
					end
				end
				default: begin
					seq_q <= lfkc_pkg::SEQ_IDLE;
				end
			endcase
		end
	end

	assign uncouple_active = running;

	seq_enable_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(seq_q == lfkc_pkg::SEQ_IDLE && tens == 4'h0) |=> seq_q == lfkc_pkg::SEQ_IDLE)
		else $error("sequence started with zero tens digit");

	speed_abort_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(running && coupler_on && speed_chg) |=> seq_q == lfkc_pkg::SEQ_DONE)
		else $error("speed change did not abort sequence");

	key_off_end_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(seq_q != lfkc_pkg::SEQ_IDLE && !coupler_on) |=> seq_q == lfkc_pkg::SEQ_IDLE)
		else $error("sequence survived coupler off");

	move_time_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(seq_q == lfkc_pkg::SEQ_MOVE && seq_tmr_q > move_tenths) |-> 1'b0)
		else $error("move-away ran past its time");

	// ****************************************
	// speed, direction and momentum
	// ****************************************
	logic shunt_on;
	logic low_gear;
	logic [7:0] sk;

	assign sk = cv_q[lfkc_pkg::CV_SHUNT];
	assign shunt_on = (sk[lfkc_pkg::SK_MAN] & manual_key) | (sk[lfkc_pkg::SK_F4] & fkeys[4])
		| (sk[lfkc_pkg::SK_F3S] & fkeys[3]);
	assign low_gear = (sk[lfkc_pkg::SK_F7L] & fkeys[7]) | (sk[lfkc_pkg::SK_F3L] & fkeys[3]);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			target_step_q <= 8'h00;
			drive_fwd_q <= 1'b1;
		end else begin
			if (running) begin
				target_step_q <= move_step;
			end else if (low_gear) begin
				target_step_q <= {1'b0, cab_speed};
			end else begin
				target_step_q <= {cab_speed, 1'b0};
			end
			drive_fwd_q <= (seq_q == lfkc_pkg::SEQ_PUSH) ? !cab_fwd : cab_fwd;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			accel_rate_q <= 8'h00;
			decel_rate_q <= 8'h00;
		end else if (running || !shunt_on) begin
			accel_rate_q <= cv_q[lfkc_pkg::CV_ACCEL];
			decel_rate_q <= cv_q[lfkc_pkg::CV_DECEL];
		end else begin
			accel_rate_q <= sk[lfkc_pkg::SK_HALF] ? cv_q[lfkc_pkg::CV_ACCEL] >> 1 : 8'h00;
			decel_rate_q <= sk[lfkc_pkg::SK_HALF] ? cv_q[lfkc_pkg::CV_DECEL] >> 1 : 8'h00;
		end
	end

	assign target_step = target_step_q;
	assign drive_fwd = drive_fwd_q;
	assign accel_rate = accel_rate_q;
	assign decel_rate = decel_rate_q;

	push_dir_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(seq_q == lfkc_pkg::SEQ_PUSH) |=> (drive_fwd_q == !$past(cab_fwd) && target_step_q == $past(move_step)))
		else $error("push phase direction or step wrong");

	move_dir_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(seq_q == lfkc_pkg::SEQ_MOVE) |=> (drive_fwd_q == $past(cab_fwd) && target_step_q == $past(move_step)))
		else $error("move-away direction or step wrong");

	low_gear_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(low_gear && !running) |=> target_step_q == {1'b0, $past(cab_speed)})
		else $error("low gear did not halve speed range");

	shunt_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(shunt_on && !running && !sk[lfkc_pkg::SK_HALF]) |=> (accel_rate_q == 8'h00 && decel_rate_q == 8'h00))
		else $error("shunting key did not remove momentum");
endmodule : lfkc_top
`default_nettype wire

// File: tb/lfkc_cab_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// cab and command station stand-in
// ****************************************
module lfkc_cab_model (
	input wire logic hclk,
	output logic [12:0] fkeys,
	output logic manual_key,
	output logic cab_fwd,
	output logic [6:0] cab_speed,
	output logic loco_stopped,
	output logic pom_valid,
	output logic [7:0] pom_cv,
	output logic [7:0] pom_data
);
	initial begin
		fkeys = 13'h0000;
		manual_key = 1'b0;
		cab_fwd = 1'b1;
		cab_speed = 7'h00;
		loco_stopped = 1'b1;
		pom_valid = 1'b0;
		pom_cv = 8'h00;
		pom_data = 8'h00;
	end

	// cab state, changed right after a rising edge
	task cab(input logic [12:0] k, input logic m, input logic f, input logic [6:0] s, input logic st);
		fkeys <= k;
		manual_key <= m;
		cab_fwd <= f;
		cab_speed <= s;
		loco_stopped <= st;
	endtask : cab

	// main-track write; write only, never read back
	task pom(input logic [7:0] cv, input logic [7:0] d);
		pom_valid <= 1'b1;
		pom_cv <= cv;
		pom_data <= d;
		@(posedge hclk);
		pom_valid <= 1'b0;
		pom_cv <= ~cv;
		pom_data <= ~d;
		@(posedge hclk);
	endtask : pom
endmodule : lfkc_cab_model
`default_nettype wire

// File: tb/lfkc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module lfkc_top_test;
	localparam int TK = 20;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h00000000;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	wire [12:0] fkeys;
	wire manual_key;
	wire cab_fwd;
	wire [6:0] cab_speed;
	wire loco_stopped;
	wire pom_valid;
	wire [7:0] pom_cv;
	wire [7:0] pom_data;
	logic [13:0] func_out;
	logic [7:0] target_step;
	logic drive_fwd;
	logic [7:0] accel_rate;
	logic [7:0] decel_rate;
	logic uncouple_active;
	int n_errors = 0;
	int checked = 0;
	logic [31:0] r;
	int c;
	logic [7:0] ssel [6] = '{8'h09, 8'h09, 8'h10, 8'h04, 8'h20, 8'h03};
	logic [12:0] skey [6] = '{13'h0000, 13'h0080, 13'h0008, 13'h0010, 13'h0008, 13'h0000};
	logic sman [6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
	logic [7:0] stgt [6] = '{8'hC8, 8'h64, 8'h64, 8'hC8, 8'hC8, 8'hC8};
	logic [7:0] sacc [6] = '{8'h00, 8'h05, 8'h05, 8'h00, 8'h00, 8'h02};

	always #12.5 hclk = ~hclk;

	lfkc_top #(.TICK_CYCLES(TK)) lfkc_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fkeys(fkeys), .manual_key(manual_key),
		.cab_fwd(cab_fwd), .cab_speed(cab_speed), .loco_stopped(loco_stopped), .pom_valid(pom_valid),
		.pom_cv(pom_cv), .pom_data(pom_data), .func_out(func_out), .target_step(target_step),
		.drive_fwd(drive_fwd), .accel_rate(accel_rate), .decel_rate(decel_rate),
		.uncouple_active(uncouple_active));

	lfkc_cab_model lfkc_cab_model_i (.hclk(hclk), .fkeys(fkeys), .manual_key(manual_key), .cab_fwd(cab_fwd),
		.cab_speed(cab_speed), .loco_stopped(loco_stopped), .pom_valid(pom_valid), .pom_cv(pom_cv),
		.pom_data(pom_data));

	// ****************************************
	// helpers
	// ****************************************
	task complete_run;
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : complete_run

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task stuck(input string nm);
		n_errors++;
		$display("[FAIL] %s expected done seen timeout", nm);
		complete_run();
	endtask : stuck

	task tick(input int n);
		repeat (n) @(posedge hclk);
	endtask : tick

	task rdy;
		int i;
		for (i = 0; i < 50; i++) begin
			@(posedge hclk);
			if (hreadyout === 1'b1) break;
		end
		if (i == 50) stuck("hready");
	endtask : rdy

	task bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {20'h00000, a};
		hwrite <= w;
		htrans <= 2'h2;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		rdy();
		r = hrdata;
	endtask : bus

	task wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h00000000);
		chk(nm, r, exp);
	endtask : rd

	task sts(input logic [2:0] exp);
		bus(1'b0, lfkc_pkg::STAT_OFF, 32'h00000000);
		chk("state", {29'h0, r[18:16]}, {29'h0, exp});
	endtask : sts

	task wait_act(input logic v, input int lim);
		for (c = 0; c < lim; c++) begin
			if (uncouple_active === v) break;
			@(posedge hclk);
		end
		if (c == lim) stuck("uncouple_active");
	endtask : wait_act

	task drv(input logic [12:0] k, input logic m, input logic f, input logic [6:0] s, input logic st);
		lfkc_cab_model_i.cab(k, m, f, s, st);
		tick(3);
	endtask : drv

	// ****************************************
	// test sequence
	// ****************************************
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		tick(2);
		chk("func_out", func_out, 32'h0);
		chk("hresp", {31'h0, hresp}, 32'h0);
		rd("keymap f0", 12'h084, 32'h1);
		rd("keymap f1", 12'h08C, 32'h4);
		rd("ctrl", lfkc_pkg::CTRL_OFF, 32'h2);
		wr(12'h800, 32'h5A);
		rd("unmapped", 12'h800, 32'h0);
		$display("test reset finished");
		lfkc_cab_model_i.pom(8'h03, 8'h05);
		lfkc_cab_model_i.pom(8'h04, 8'h07);
		lfkc_cab_model_i.pom(8'h74, 8'h9B);
		drv(13'h0002, 1'b0, 1'b1, 7'h00, 1'b1);
		wait_act(1'b1, 40);
		tick(3);
		chk("push dir", drive_fwd, 32'h0);
		tick(100);
		chk("move dir", drive_fwd, 32'h1);
		chk("move step", target_step, 32'h14);
		chk("move accel", accel_rate, 32'h5);
		chk("move decel", decel_rate, 32'h7);
		wait_act(1'b0, 400);
		chk("sequence time", (c + 103 >= 240) && (c + 103 <= 310), 32'h1);
		sts(3'h4);
		drv(13'h0000, 1'b0, 1'b1, 7'h00, 1'b1);
		sts(3'h0);
		$display("test uncouple finished");
		lfkc_cab_model_i.pom(8'h74, 8'h32);
		drv(13'h0002, 1'b0, 1'b1, 7'h00, 1'b1);
		wait_act(1'b1, 40);
		tick(20);
		drv(13'h0002, 1'b0, 1'b1, 7'h03, 1'b1);
		chk("abort", uncouple_active, 32'h0);
		sts(3'h4);
		drv(13'h0000, 1'b0, 1'b1, 7'h00, 1'b1);
		drv(13'h0002, 1'b0, 1'b1, 7'h00, 1'b0);
		sts(3'h1);
		chk("wait idle", uncouple_active, 32'h0);
		lfkc_cab_model_i.cab(13'h0002, 1'b0, 1'b1, 7'h00, 1'b1);
		wait_act(1'b1, 40);
		lfkc_cab_model_i.cab(13'h0000, 1'b0, 1'b1, 7'h00, 1'b1);
		wait_act(1'b0, 10);
		lfkc_cab_model_i.pom(8'h74, 8'h05);
		drv(13'h0002, 1'b0, 1'b1, 7'h00, 1'b1);
		tick(4);
		chk("disabled", uncouple_active, 32'h0);
		sts(3'h0);
		chk("coupler held", func_out, 32'h4);
		lfkc_cab_model_i.pom(8'h73, 8'h02);
		tick(70);
		chk("coupler limit", func_out, 32'h0);
		lfkc_cab_model_i.pom(8'h73, 8'h00);
		$display("test abort and start finished");
		for (int i = 0; i < 6; i++) begin
			lfkc_cab_model_i.pom(8'h7C, ssel[i]);
			drv(skey[i], sman[i], 1'b1, 7'h64, 1'b0);
			chk("speed", target_step, stgt[i]);
			chk("momentum", accel_rate, sacc[i]);
		end
		lfkc_cab_model_i.pom(8'h7C, 8'h00);
		$display("test shunt finished");
		wr(lfkc_pkg::CTRL_OFF, 32'hD);
		for (int n = 0; n < 13; n++) begin
			drv(13'h0001 << n, 1'b0, 1'b1, 7'h00, 1'b1);
			chk("map", func_out, (n == 0) ? 32'h1 : 32'h1 << (n + 1));
		end
		drv(13'h0001, 1'b0, 1'b0, 7'h00, 1'b1);
		chk("map rev", func_out, 32'h2);
		bus(1'b0, lfkc_pkg::STAT_OFF, 32'h0);
		chk("status out", {18'h0, r[13:0]}, 32'h2);
		wr(12'h090, 32'h28);
		drv(13'h0004, 1'b0, 1'b1, 7'h00, 1'b1);
		chk("multi map", func_out, 32'h28);
		wr(12'h08C, 32'hC);
		lfkc_cab_model_i.pom(8'h7F, 8'h01);
		lfkc_cab_model_i.pom(8'h80, 8'h02);
		drv(13'h0002, 1'b0, 1'b1, 7'h00, 1'b1);
		chk("effect fwd", func_out, 32'h4);
		drv(13'h0002, 1'b0, 1'b0, 7'h00, 1'b1);
		chk("effect rev", func_out, 32'h8);
		lfkc_cab_model_i.pom(8'h80, 8'h06);
		drv(13'h0002, 1'b0, 1'b1, 7'h00, 1'b1);
		chk("effect bits", func_out, 32'hC);
		$display("test mapping finished");
		for (int m = 6; m < 8; m++) begin
			lfkc_cab_model_i.pom(8'h3D, 8'(m));
			drv(13'h0001, 1'b0, 1'b1, 7'h00, 1'b1);
			chk("ext fwd", func_out, 32'h5);
			drv(13'h0001, 1'b0, 1'b0, 7'h00, 1'b1);
			chk("ext rev", func_out, 32'hA);
		end
		lfkc_cab_model_i.pom(8'h3D, 8'h62);
		wr(lfkc_pkg::AUTO_OFF_OFF, 32'h1);
		drv(13'h0001, 1'b0, 1'b1, 7'h00, 1'b1);
		chk("auto off", func_out, 32'h0);
		drv(13'h0001, 1'b0, 1'b1, 7'h00, 1'b0);
		chk("auto on", func_out, 32'h1);
		$display("test extended finished");
		lfkc_cab_model_i.pom(8'h01, 8'h55);
		lfkc_cab_model_i.pom(8'h11, 8'h55);
		rd("addr short", 12'h004, 32'h0);
		rd("addr long", 12'h044, 32'h0);
		rd("accel var", 12'h00C, 32'h5);
		$display("test main write finished");
		complete_run();
	end
endmodule : lfkc_top_test
`default_nettype wire
